// *** tmecc_pkg.sv ***
// Shared constants for the timer event counter control block
package tmecc_pkg;
  // Register byte addresses
  localparam logic [31:0] TMECC_ADDR_RUN = 32'hffffc700;
  localparam logic [31:0] TMECC_ADDR_MODE_LO = 32'hffffc704;
  localparam logic [31:0] TMECC_ADDR_MODE_HI = 32'hffffc705;
  localparam logic [31:0] TMECC_ADDR_CMP0 = 32'hffffc70c;
  localparam logic [31:0] TMECC_ADDR_CMP1 = 32'hffffc710;
  localparam logic [31:0] TMECC_ADDR_CAP0 = 32'hffffc714;
  localparam logic [31:0] TMECC_ADDR_CNT = 32'hffffc71c;
  localparam logic [31:0] TMECC_ADDR_STAT = 32'hffffc720;
  // Run register fields
  localparam int TMECC_RUN_TIMER = 0;
  localparam int TMECC_RUN_OVF_IE = 1;
  localparam int TMECC_RUN_PRESC = 2;
  localparam int TMECC_RUN_IDLE = 3;
  localparam int TMECC_RUN_SRC = 4;
  localparam int TMECC_RUN_EDGE = 5;
  localparam int TMECC_RUN_DBUF = 7;
  // Mode low fields
  localparam int TMECC_MODE_CLK_LSB = 0;
  localparam int TMECC_MODE_CLE = 3;
  localparam int TMECC_MODE_CPM_LSB = 4;
  // Mode high fields
  localparam int TMECC_MODEH_SWCAP = 0;
  localparam int TMECC_MODEH_RSVD = 1;
  // Reset values
  localparam logic [7:0] TMECC_RUN_RST = 8'h00;
  localparam logic [7:0] TMECC_MODE_LO_RST = 8'h00;
  localparam logic [1:0] TMECC_CPM_OFF = 2'h0;
  // Clock source codes
  typedef enum logic [2:0] {
    TMECC_CLK_PIN = 3'b000,
    TMECC_CLK_DIV1 = 3'b001,
    TMECC_CLK_DIV32 = 3'b110
  } tmecc_clk_e;
  localparam int TMECC_DIV_W = 5;
endpackage : tmecc_pkg

// *** tmecc_tick_if.sv ***
// Count tick and trigger edge carrier between control and prescaler
`timescale 1ns/1ps
`default_nettype none
interface tmecc_tick_if;
  logic presc_run;
  logic [2:0] clk_sel;
  logic count_tick;
  logic pin_rise;
  logic pin_fall;
  modport gen (input presc_run, input clk_sel, output count_tick, output pin_rise, output pin_fall);
  modport ctl (output presc_run, output clk_sel, input count_tick, input pin_rise, input pin_fall);
endinterface : tmecc_tick_if
`default_nettype wire

// *** tmecc_prescaler.sv ***
// Prescaler and trigger pin synchroniser producing count ticks
`timescale 1ns/1ps
`default_nettype none
module tmecc_prescaler
  import tmecc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Trigger pin
  input wire logic trigger_input_pin,
  // Tick carrier
  tmecc_tick_if.gen tk
);
  typedef struct packed {
    logic [2:0] sync;
    logic lvl;
    logic rise;
    logic fall;
    logic [TMECC_DIV_W-1:0] div;
  } tmecc_psc_s;

  tmecc_psc_s s_q, s_d;
  logic [TMECC_DIV_W-1:0] mask;
  logic int_tick;

  // Divide by 2^(sel-1): tick when the low sel-1 bits are all ones
  always_comb begin
    mask = TMECC_DIV_W'((32'h1 << (tk.clk_sel - 3'h1)) - 32'h1);
    int_tick = tk.presc_run && (tk.clk_sel >= TMECC_CLK_DIV1) && (tk.clk_sel <= TMECC_CLK_DIV32) &&
               ((s_q.div & mask) == mask);
    tk.count_tick = (tk.clk_sel == TMECC_CLK_PIN) ? s_q.rise : int_tick;
    tk.pin_rise = s_q.rise;
    tk.pin_fall = s_q.fall;
  end

  always_comb begin
    s_d = s_q;
    s_d.sync = {s_q.sync[1:0], trigger_input_pin};
    s_d.rise = 1'b0;
    s_d.fall = 1'b0;
    // Level changes only when stages two and three agree, filtering one-cycle glitches
    if (s_q.sync[2] == s_q.sync[1] && s_q.sync[2] != s_q.lvl) begin
      s_d.lvl = s_q.sync[2];
      s_d.rise = s_q.sync[2];
      s_d.fall = !s_q.sync[2];
    end
    // Stopped prescaler is cleared so the first tick after restart has a full period
    s_d.div = tk.presc_run ? s_q.div + TMECC_DIV_W'(1) : '0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
endmodule : tmecc_prescaler
`default_nettype wire

// *** tmecc_top.sv ***
// Run and mode control of a 16-bit timer/event counter
`timescale 1ns/1ps
`default_nettype none
module tmecc_top
  import tmecc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Trigger pin
  input wire logic trigger_input_pin,
  // Events
  output logic overflow_irq,
  output logic compare0_irq,
  output logic compare1_irq,
  output logic match0_pulse,
  output logic match1_pulse,
  output logic [CNT_W-1:0] up_counter_value
);
  import tmecc_pkg::*;

  if (CNT_W < 8 || CNT_W > 16) begin : g_chk
    $error("CNT_W must be between 8 and 16");
  end

  // The prescaler's divide counter must span the widest divider, by 32
  if (TMECC_DIV_W < 5) begin : g_div_chk
    $error("TMECC_DIV_W must be at least 5");
  end

  typedef struct packed {
    logic [7:0] run;
    logic [7:0] mode_lo;
    logic mode_hi_rsvd;
    logic [CNT_W-1:0] cmp0_buf;
    logic [CNT_W-1:0] cmp0;
    logic [CNT_W-1:0] cmp1;
    logic [CNT_W-1:0] cap0;
    logic [CNT_W-1:0] cnt;
    logic trig_held;
    logic [15:0] rdata;
    logic ovf_irq;
    logic c0_irq;
    logic c1_irq;
    logic m0;
    logic m1;
  } tmecc_top_s;

  tmecc_top_s s_q, s_d;
  tmecc_tick_if tk ();

  logic timer_run_bit, overflow_interrupt_enable, prescaler_run, idle_hold_control;
  logic count_start_source_select, trigger_edge_select, double_buffer_enable;
  logic clear_on_match;
  logic [1:0] capture_mode_field;
  logic sel_edge, started, counting, hit0, hit1, ovf, wrap;
  logic [CNT_W-1:0] wd;

  tmecc_prescaler u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .trigger_input_pin(trigger_input_pin),
    .tk(tk.gen)
  );

  always_comb begin
    timer_run_bit = s_q.run[TMECC_RUN_TIMER];
    overflow_interrupt_enable = s_q.run[TMECC_RUN_OVF_IE];
    prescaler_run = s_q.run[TMECC_RUN_PRESC];
    idle_hold_control = s_q.run[TMECC_RUN_IDLE];
    count_start_source_select = s_q.run[TMECC_RUN_SRC];
    trigger_edge_select = s_q.run[TMECC_RUN_EDGE];
    double_buffer_enable = s_q.run[TMECC_RUN_DBUF];
    clear_on_match = s_q.mode_lo[TMECC_MODE_CLE];
    capture_mode_field = s_q.mode_lo[TMECC_MODE_CPM_LSB +: 2];
    // Run and select bits go to the prescaler straight from the registers
    tk.presc_run = prescaler_run;
    tk.clk_sel = s_q.mode_lo[TMECC_MODE_CLK_LSB +: 3];
    wd = reg_wdata[CNT_W-1:0];
  end

  always_comb begin
    // Edges come from the filtered pin, so a one-cycle glitch never starts the timer
    sel_edge = trigger_edge_select ? tk.pin_fall : tk.pin_rise;
    started = count_start_source_select ? s_q.trig_held : 1'b1;
    counting = timer_run_bit && idle_hold_control && started && tk.count_tick;
    // Compare 0 never matches at zero; compare 1 does
    hit0 = counting && (s_q.cmp0 != '0) && (s_q.cnt == s_q.cmp0);
    hit1 = counting && (s_q.cnt == s_q.cmp1);
    ovf = counting && (s_q.cnt == {CNT_W{1'b1}});
    wrap = (hit1 && clear_on_match) || ovf;
  end

  always_comb begin
    s_d = s_q;
    s_d.ovf_irq = 1'b0;
    s_d.c0_irq = 1'b0;
    s_d.c1_irq = 1'b0;
    s_d.m0 = hit0;
    s_d.m1 = hit1;
    s_d.rdata = '0;

    // Counter
    if (!timer_run_bit) begin
      s_d.cnt = '0;
      s_d.trig_held = 1'b0;
    end else begin
      // Only the first accepted edge latches; later edges fall through unused
      if (count_start_source_select && !s_q.trig_held && sel_edge) begin
        s_d.trig_held = 1'b1;
      end
      // Compare 1 at zero with clear-on-match pins the counter at zero
      if (hit1 && clear_on_match) begin
        s_d.cnt = '0;
      end else if (counting) begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
      end
    end

    // Buffered compare value moves over at the end of each counting cycle
    if (double_buffer_enable && wrap) begin
      s_d.cmp0 = s_q.cmp0_buf;
    end

    // Event outputs are one-cycle pulses; a low clock enable stretches them
    s_d.ovf_irq = ovf && overflow_interrupt_enable;
    s_d.c0_irq = hit0 && (capture_mode_field == TMECC_CPM_OFF);
    s_d.c1_irq = hit1 && (capture_mode_field == TMECC_CPM_OFF);

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        TMECC_ADDR_RUN: begin
          // Bit 6 is kept as written; software is expected to leave it zero
          s_d.run = reg_wdata[7:0];
        end
        TMECC_ADDR_MODE_LO: begin
          // Bits 7 and 6 do not exist and read back as zero
          s_d.mode_lo = reg_wdata[7:0] & 8'h3f;
        end
        TMECC_ADDR_MODE_HI: begin
          // Writing 0 to bit 0 captures; it reads back as one, so a bit read-modify-write fires no capture
          s_d.mode_hi_rsvd = reg_wdata[TMECC_MODEH_RSVD];
          if (!reg_wdata[TMECC_MODEH_SWCAP]) begin
            s_d.cap0 = s_q.cnt;
          end
        end
        TMECC_ADDR_CMP0: begin
          s_d.cmp0_buf = wd;
          if (!double_buffer_enable) begin
            s_d.cmp0 = wd;
          end
        end
        TMECC_ADDR_CMP1: begin
          s_d.cmp1 = wd;
        end
        default: begin
        end
      endcase
    end

    // Register reads, data valid the following cycle
    if (reg_rd) begin
      case (reg_addr)
        TMECC_ADDR_RUN: s_d.rdata = {8'h00, s_q.run};
        TMECC_ADDR_MODE_LO: s_d.rdata = {8'h00, s_q.mode_lo};
        TMECC_ADDR_MODE_HI: s_d.rdata = {14'h0000, s_q.mode_hi_rsvd, 1'b1};
        // Compare 0 reads back the last value written, not the active one
        TMECC_ADDR_CMP0: s_d.rdata = 16'(s_q.cmp0_buf);
        TMECC_ADDR_CMP1: s_d.rdata = 16'(s_q.cmp1);
        TMECC_ADDR_CAP0: s_d.rdata = 16'(s_q.cap0);
        TMECC_ADDR_CNT: s_d.rdata = 16'(s_q.cnt);
        // Status shows whether a trigger start has been taken
        TMECC_ADDR_STAT: s_d.rdata = {14'h0000, s_q.trig_held, started};
        default: s_d.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Reset does not wait for the clock enable, so a frozen block still starts clean
      s_q <= '0;
      s_q.run <= TMECC_RUN_RST;
      s_q.mode_lo <= TMECC_MODE_LO_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign overflow_irq = s_q.ovf_irq;
  assign compare0_irq = s_q.c0_irq;
  assign compare1_irq = s_q.c1_irq;
  assign match0_pulse = s_q.m0;
  assign match1_pulse = s_q.m1;
  assign up_counter_value = s_q.cnt;
endmodule : tmecc_top
`default_nettype wire

// *** tmecc_asserts.sv ***
// Port checks for the timer run and mode control
`timescale 1ns/1ps
`default_nettype none
module tmecc_asserts
  import tmecc_pkg::*;
#(parameter int CNT_W = 16) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Events
  input wire logic overflow_irq,
  input wire logic compare1_irq,
  input wire logic match1_pulse,
  input wire logic [CNT_W-1:0] up_counter_value
);
  // Shadow control bytes, so every check sees the same cycle as the design
  logic [7:0] run_q;
  logic [7:0] mode_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      run_q <= 8'h00;
      mode_q <= 8'h00;
    end else if (ce && reg_wr && reg_addr == TMECC_ADDR_RUN) begin
      run_q <= reg_wdata[7:0];
    end else if (ce && reg_wr && reg_addr == TMECC_ADDR_MODE_LO) begin
      mode_q <= reg_wdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_run_off;
    !run_q[0] ##1 !run_q[0];
  endsequence
  sequence s_frozen;
    run_q[0] && !run_q[3];
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata not idle");
  a_swcap_one: assert property (reg_rd && reg_addr == TMECC_ADDR_MODE_HI |=> reg_rdata[0]) else $error("swcap");
  a_stop_clear: assert property (s_run_off |-> up_counter_value == '0) else $error("not cleared");
  a_idle_freeze: assert property (s_frozen |=> $stable(up_counter_value)) else $error("not held");
  a_ovf_gate: assert property (overflow_irq |-> ($past(run_q) & 8'h02) != 8'h00 && $past(up_counter_value) == '1)
    else $error("ovf cause");
  a_wrap_raise: assert property (($past(run_q) & 8'h03) == 8'h03 && ($past(mode_q) & 8'h08) == 8'h00
    && $past(up_counter_value) == '1 && up_counter_value == '0 |-> overflow_irq) else $error("ovf miss");
  a_cmp1_mode: assert property (compare1_irq |-> match1_pulse && ($past(mode_q) & 8'h30) == 8'h00)
    else $error("cmp irq");
  a_cmp1_raise: assert property (match1_pulse && ($past(mode_q) & 8'h30) == 8'h00 |-> compare1_irq)
    else $error("cmp miss");
  a_cle_clear: assert property (match1_pulse && ($past(mode_q) & 8'h08) != 8'h00 |-> up_counter_value == '0)
    else $error("cle");
endmodule : tmecc_asserts
bind tmecc_top tmecc_asserts #(.CNT_W(CNT_W)) tmecc_asserts_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .overflow_irq(overflow_irq), .compare1_irq(compare1_irq), .match1_pulse(match1_pulse),
  .up_counter_value(up_counter_value));
`default_nettype wire

// *** tmecc_pin_model.sv ***
// Trigger pin source standing in for the external pulse generator
`timescale 1ns/1ps
`default_nettype none
module tmecc_pin_model (
  // Clock and pin
  input wire logic clk,
  output logic trigger_input_pin
);
  initial trigger_input_pin = 1'b0;
  // Levels are held well past the two-cycle filter minimum
  task automatic drive_level(input logic lvl);
    @(posedge clk);
    trigger_input_pin <= lvl;
    repeat (9) @(posedge clk);
  endtask : drive_level
endmodule : tmecc_pin_model
`default_nettype wire

// *** tmecc_top_bench.sv ***
// Bench for the timer run and mode control
`timescale 1ns/1ps
`default_nettype none
module tmecc_top_bench;
  import tmecc_pkg::*;
  localparam int CNT_W = 8;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ce = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata;
  logic pin, ovf, c0i, c1i, m0, m1;
  logic [CNT_W-1:0] cnt, snap;
  int err_count = 0, n_tests = 0, n_ovf, n_m1, n_c1, hi, n_m0, n_c0, first_m0, last_m0;
  always #4 clk = ~clk;
  tmecc_pin_model tmecc_pin_model_inst (.clk(clk), .trigger_input_pin(pin));
  tmecc_top #(.CNT_W(CNT_W)) tmecc_top_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_input_pin(pin),
    .overflow_irq(ovf), .compare0_irq(c0i), .compare1_irq(c1i), .match0_pulse(m0), .match1_pulse(m1),
    .up_counter_value(cnt));
  task automatic ck(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : ck
  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 ck(reg_rdata, e);
  endtask : rd
  task automatic watch(input int n);
    n_ovf = 0;
    n_m1 = 0;
    n_c1 = 0;
    hi = 0;
    n_m0 = 0;
    n_c0 = 0;
    first_m0 = -1;
    last_m0 = -1;
    repeat (n) begin
      @(posedge clk);
      #1 n_ovf += int'(ovf);
      n_m1 += int'(m1);
      n_c1 += int'(c1i);
      if (int'(cnt) > hi) hi = int'(cnt);
      n_m0 += int'(m0);
      n_c0 += int'(c0i);
      if (m0 === 1'b1 && first_m0 < 0) first_m0 = int'(cnt);
      if (m0 === 1'b1) last_m0 = int'(cnt);
    end
  endtask : watch
  task automatic t_regs();
    rd(TMECC_ADDR_RUN, 16'h0000);
    rd(TMECC_ADDR_MODE_HI, 16'h0001);
    rd(32'hffffc7f0, 16'h0000);
    wr(TMECC_ADDR_RUN, 16'h00a6);
    rd(TMECC_ADDR_RUN, 16'h00a6);
    wr(TMECC_ADDR_MODE_LO, 16'h00ff);
    rd(TMECC_ADDR_MODE_LO, 16'h003f);
    wr(TMECC_ADDR_RUN, 16'h0000);
  endtask : t_regs
  task automatic t_count();
    wr(TMECC_ADDR_CMP1, 16'h0010);
    wr(TMECC_ADDR_MODE_LO, 16'h0009);
    wr(TMECC_ADDR_RUN, 16'h000f);
    watch(100);
    ck(16'(hi), 16'h0010);
    ck(16'(n_c1 == n_m1 && n_m1 > 0), 16'h0001);
    ck(16'(n_ovf), 16'h0000);
    wr(TMECC_ADDR_MODE_LO, 16'h0019);
    watch(100);
    ck(16'(n_c1 == 0 && n_m1 > 0), 16'h0001);
    wr(TMECC_ADDR_MODE_LO, 16'h0001);
    watch(300);
    ck(16'(n_ovf > 0), 16'h0001);
    wr(TMECC_ADDR_RUN, 16'h000d);
    watch(300);
    ck(16'(n_ovf), 16'h0000);
    wr(TMECC_ADDR_RUN, 16'h0005);
    watch(2);
    snap = cnt;
    watch(20);
    ck(16'(cnt), 16'(snap));
    wr(TMECC_ADDR_MODE_HI, 16'h0000);
    rd(TMECC_ADDR_CAP0, 16'(snap));
    wr(TMECC_ADDR_RUN, 16'h000d);
    watch(5);
    wr(TMECC_ADDR_RUN, 16'h0005);
    wr(TMECC_ADDR_MODE_HI, 16'h0001);
    rd(TMECC_ADDR_CAP0, 16'(snap));
    wr(TMECC_ADDR_RUN, 16'h0004);
    watch(2);
    ck(16'(cnt), 16'h0000);
  endtask : t_count
  task automatic t_trig();
    wr(TMECC_ADDR_RUN, 16'h001c);
    tmecc_pin_model_inst.drive_level(1'b1);
    ck(16'(cnt), 16'h0000);
    tmecc_pin_model_inst.drive_level(1'b0);
    wr(TMECC_ADDR_RUN, 16'h001d);
    watch(10);
    ck(16'(cnt), 16'h0000);
    tmecc_pin_model_inst.drive_level(1'b1);
    ck(16'(cnt != '0), 16'h0001);
    tmecc_pin_model_inst.drive_level(1'b0);
    wr(TMECC_ADDR_RUN, 16'h003c);
    tmecc_pin_model_inst.drive_level(1'b1);
    wr(TMECC_ADDR_RUN, 16'h003d);
    watch(10);
    ck(16'(cnt), 16'h0000);
    tmecc_pin_model_inst.drive_level(1'b0);
    ck(16'(cnt != '0), 16'h0001);
  endtask : t_trig
  // Compare 0 match pulse sits one count above the active value
  task automatic t_cmp0();
    wr(TMECC_ADDR_RUN, 16'h000c);
    wr(TMECC_ADDR_MODE_LO, 16'h0009);
    wr(TMECC_ADDR_CMP0, 16'h0005);
    wr(TMECC_ADDR_RUN, 16'h000d);
    watch(40);
    ck(16'(first_m0), 16'h0006);
    ck(16'(n_c0 == n_m0 && n_m0 > 0), 16'h0001);
    wr(TMECC_ADDR_RUN, 16'h0084);
    wr(TMECC_ADDR_CMP0, 16'h0007);
    rd(TMECC_ADDR_CMP0, 16'h0007);
    wr(TMECC_ADDR_MODE_LO, 16'h0029);
    wr(TMECC_ADDR_RUN, 16'h008d);
    watch(60);
    ck(16'(first_m0), 16'h0006);
    ck(16'(last_m0), 16'h0008);
    ck(16'(n_c0 == 0 && n_m0 > 0), 16'h0001);
    wr(TMECC_ADDR_RUN, 16'h000c);
    wr(TMECC_ADDR_MODE_LO, 16'h000b);
    wr(TMECC_ADDR_RUN, 16'h000d);
    watch(40);
    ck(16'(cnt), 16'h000a);
    wr(TMECC_ADDR_RUN, 16'h0000);
  endtask : t_cmp0
  task automatic t_freeze();
    wr(TMECC_ADDR_MODE_LO, 16'h0001);
    wr(TMECC_ADDR_RUN, 16'h000d);
    watch(5);
    @(posedge clk);
    ce <= 1'b0;
    watch(1);
    snap = cnt;
    watch(12);
    ck(16'(cnt), 16'(snap));
    @(posedge clk);
    ce <= 1'b1;
    watch(3);
    snap = snap + CNT_W'(3);
    ck(16'(cnt), 16'(snap));
    wr(TMECC_ADDR_RUN, 16'h0000);
  endtask : t_freeze
  task automatic end_of_test();
    $display("tests=%0d errors=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_count();
    t_trig();
    t_cmp0();
    t_freeze();
    end_of_test();
  end
  // Whole run needs about 1200 cycles
  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    end_of_test();
  end
endmodule : tmecc_top_bench
`default_nettype wire
